/* File: reset_seq_pkg.sv */
`default_nettype none
package reset_seq_pkg;

    // ****************************************
    // timing figures
    // ****************************************
    localparam int CLK_PERIOD_PS = 5000;
    localparam int ASSERT_DELAY_NS = 20000;
    localparam int MANUAL_MIN_NS = 15000;
    localparam int RELEASE_DELAY_50_MS = 50;
    localparam int RELEASE_DELAY_100_MS = 100;
    localparam int RELEASE_DELAY_200_MS = 200;
    localparam int PS_PER_MS = 1000000000;
    localparam int PS_PER_NS = 1000;
    localparam int ASSERT_CYCLES = (ASSERT_DELAY_NS * PS_PER_NS) / CLK_PERIOD_PS;
    localparam int MANUAL_CYCLES = (MANUAL_MIN_NS * PS_PER_NS) / CLK_PERIOD_PS;
    localparam longint RELEASE_CYCLES_50 =
        (longint'(RELEASE_DELAY_50_MS) * PS_PER_MS) / CLK_PERIOD_PS;
    localparam int CNT_W = 32;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0]
    {
        ST_HOLD = 2'b00,
        ST_DELAY = 2'b01,
        ST_RELEASED = 2'b10
    } seq_state_e;

    typedef struct packed
    {
        logic out_o;
        logic out_oe;
    } reset_pin_s;

endpackage
`default_nettype wire

/* File: supply_reset_delay_sequencer.sv */
// Functional notes
// - reset stays low while the supply is below the lower threshold.
// - a supply drop asserts reset within a few cycles, inside the assert delay of 20 us.
// - the release delay runs from the upward crossing with reset held low.
// - a fixed timer delay of 50, 100 or 200 ms precedes release.
// - the delay lies within its tolerance window, 30..75 ms for 50 ms.
// - no input can change the delay length.
// - a high manual reset input asserts reset even with a good supply.
// - manual pulses of 15 us or longer are always detected.
// - the output only pulls low or floats, never drives high.
// - manual reset release starts the full delay before reset lifts.
// - release needs both a good supply and a completed delay.
`default_nettype none
module supply_reset_delay_sequencer
#(
    parameter longint RELEASE_CYCLES = reset_seq_pkg::RELEASE_CYCLES_50
)
(
    input wire logic clk,
    input wire logic arst_n,
    input wire logic undervolt,
    input wire logic manual_reset,
    output var reset_seq_pkg::reset_pin_s reset_pin
);
    import reset_seq_pkg::*;

    // ****************************************
    // input synchronisers
    // ****************************************
    logic [1:0] uv_sync_reg;
    logic [1:0] mr_sync_reg;
    logic [1:0] uv_sync_next;
    logic [1:0] mr_sync_next;

    always_comb
    begin
        uv_sync_next = {uv_sync_reg[0], undervolt};
        mr_sync_next = {mr_sync_reg[0], manual_reset};
    end

    // undervolt stages asserted and manual stages cleared at reset, so the output starts low
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            uv_sync_reg <= 2'h3;
            mr_sync_reg <= 2'h0;
        end
        else
        begin
            uv_sync_reg <= uv_sync_next;
            mr_sync_reg <= mr_sync_next;
        end
    end

    wire logic uv_s = uv_sync_reg[1];
    wire logic mr_s = mr_sync_reg[1];
    // manual level is caught within two cycles, far below the 15 us minimum
    wire logic request = uv_s | mr_s;

    // ****************************************
    // sequencer
    // ****************************************
    seq_state_e state_reg;
    seq_state_e state_next;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic low_reg;
    logic low_next;

    // the limit is a build constant only; there is no pin for it
    localparam logic [CNT_W-1:0] LAST = CNT_W'(RELEASE_CYCLES - 1);

    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        low_next = low_reg;
        case (state_reg)
            ST_HOLD:
            begin
                low_next = 1'b1;
                cnt_next = '0;
                if (!request)
                begin
                    state_next = ST_DELAY;
                end
            end
            ST_DELAY:
            begin
                low_next = 1'b1;
                if (request)
                begin
                    state_next = ST_HOLD;
                    cnt_next = '0;
                end
                else if (cnt_reg == LAST)
                begin
                    state_next = ST_RELEASED;
                    low_next = 1'b0;
                end
                else
                begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            ST_RELEASED:
            begin
                low_next = 1'b0;
                // reacts within a few cycles, well inside the 20 us figure
                if (request)
                begin
                    state_next = ST_HOLD;
                    low_next = 1'b1;
                end
            end
            default:
            begin
                state_next = ST_HOLD;
                low_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= ST_HOLD;
            cnt_reg <= '0;
            low_reg <= 1'b1;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            low_reg <= low_next;
        end
    end

    // ****************************************
    // open-drain output
    // ****************************************
    // data is always low; only the enable moves, so the pin never sources high
    always_comb
    begin
        reset_pin.out_o = 1'b0;
        reset_pin.out_oe = low_reg;
    end

    // ****************************************
    // checks
    // ****************************************
    // helper: cycles since the synchronised request last read high; it saturates so a long
    // released spell cannot wrap back to a small value
    logic [CNT_W-1:0] quiet_reg;
    logic [CNT_W-1:0] quiet_next;
    localparam logic [CNT_W-1:0] QUIET_AT_RELEASE = CNT_W'(RELEASE_CYCLES + 1);

    always_comb
    begin
        quiet_next = quiet_reg;
        if (request)
        begin
            quiet_next = '0;
        end
        else if (quiet_reg != '1)
        begin
            quiet_next = quiet_reg + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            quiet_reg <= '0;
        end
        else
        begin
            quiet_reg <= quiet_next;
        end
    end

    a_never_high: assert property (@(posedge clk) disable iff (!arst_n)
        reset_pin.out_o == 1'b0)
        else $error("reset pin driven high");

    a_uv_assert_fast: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(undervolt) ##0 !$past(undervolt) |-> ##[1:4] reset_pin.out_oe)
        else $error("undervoltage not asserted in time");

    a_manual_holds: assert property (@(posedge clk) disable iff (!arst_n)
        mr_s |=> reset_pin.out_oe)
        else $error("manual reset not holding output");

    a_uv_holds: assert property (@(posedge clk) disable iff (!arst_n)
        uv_s |=> reset_pin.out_oe)
        else $error("undervoltage not holding output");

    a_release_cond: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(reset_pin.out_oe) |-> $past(state_reg) == ST_DELAY && $past(cnt_reg) == LAST
            && !$past(request))
        else $error("release without completed delay");

    a_restart_zero: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_DELAY && request |=> cnt_reg == '0 && state_reg == ST_HOLD)
        else $error("delay not restarted");

    a_delay_held: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_DELAY |-> reset_pin.out_oe)
        else $error("output released during delay");

    a_count_step: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_DELAY && !request && cnt_reg != LAST |=> cnt_reg == $past(cnt_reg) + 1)
        else $error("delay counter stalled");

    a_delay_length: assert property (@(posedge clk) disable iff (!arst_n)
        $fell(reset_pin.out_oe) |-> quiet_reg == QUIET_AT_RELEASE)
        else $error("release delay length wrong");

    a_manual_assert: assert property (@(posedge clk) disable iff (!arst_n)
        $rose(manual_reset) |-> ##[1:4] reset_pin.out_oe)
        else $error("manual reset not asserted in time");

    a_hold_clears: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_HOLD |=> cnt_reg == '0)
        else $error("count not cleared in hold");

    a_delay_entry: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_HOLD && !request |=> state_reg == ST_DELAY && reset_pin.out_oe)
        else $error("delay not started on request clear");

    a_release_only: assert property (@(posedge clk) disable iff (!arst_n)
        !reset_pin.out_oe |-> state_reg == ST_RELEASED && quiet_reg > LAST)
        else $error("output released outside released state");

    a_request_exit: assert property (@(posedge clk) disable iff (!arst_n)
        state_reg == ST_RELEASED && request |=> state_reg == ST_HOLD && reset_pin.out_oe)
        else $error("request did not reassert output");

endmodule // supply_reset_delay_sequencer
`default_nettype wire

/* File: reset_target_model.sv */
`default_nettype none
module reset_target_model
(
    input var reset_seq_pkg::reset_pin_s reset_pin,
    output var logic line_level
);
    timeunit 1ns;
    timeprecision 1ps;
    import reset_seq_pkg::*;
    // pull-up on the line: a released pin reads high, a driven one its data
    assign line_level = reset_pin.out_oe ? reset_pin.out_o : 1'b1;
endmodule // reset_target_model
`default_nettype wire

/* File: supply_reset_delay_sequencer_tb_top.sv */
`default_nettype none
module supply_reset_delay_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import reset_seq_pkg::*;
    // ****************************************
    // harness
    // ****************************************
    // short count keeps the run small; expectations derive from it
    localparam longint RC = 20;
    localparam int LAT = 3 + int'(RC);
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    logic undervolt = 1'b1;
    logic manual_reset = 1'b0;
    reset_pin_s reset_pin;
    logic line_level;
    int errors = 0;
    int check_count = 0;
    int cyc = 0;
    int n;
    supply_reset_delay_sequencer #(.RELEASE_CYCLES(RC)) supply_reset_delay_sequencer_i
    (
        .clk(clk),
        .arst_n(arst_n),
        .undervolt(undervolt),
        .manual_reset(manual_reset),
        .reset_pin(reset_pin)
    );
    reset_target_model reset_target_model_i
    (
        .reset_pin(reset_pin),
        .line_level(line_level)
    );
    initial forever #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    // ****************************************
    // tasks
    // ****************************************
    task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic drive(logic uv, logic mr, int wait_n);
        @(posedge clk);
        undervolt <= uv;
        manual_reset <= mr;
        repeat (wait_n) @(posedge clk);
        #1;
    endtask
    // bounded wait for the line to read high, counting edges
    task automatic settle(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1;
            cnt++;
        end while (line_level !== 1'b1 && cnt < 200);
    endtask
    task automatic t_power_up();
        chk("line in reset", line_level, 1'b0);
        drive(1'b0, 1'b0, 0);
        settle(n);
        chk("power up delay", n, LAT);
        chk("pin data", reset_pin.out_o, 1'b0);
    endtask
    task automatic t_undervolt();
        drive(1'b1, 1'b0, 3);
        chk("undervolt assert", line_level, 1'b0);
        drive(1'b1, 1'b0, 60);
        chk("undervolt hold", line_level, 1'b0);
        drive(1'b0, 1'b0, 0);
        settle(n);
        chk("undervolt release", n, LAT);
    endtask
    task automatic t_manual();
        drive(1'b0, 1'b1, 3);
        chk("manual assert", line_level, 1'b0);
        drive(1'b0, 1'b1, MANUAL_CYCLES);
        drive(1'b0, 1'b0, 0);
        settle(n);
        chk("manual release", n, LAT);
    endtask
    task automatic t_restart();
        drive(1'b1, 1'b0, 5);
        drive(1'b0, 1'b0, 13);
        drive(1'b0, 1'b1, 5);
        drive(1'b0, 1'b0, 0);
        settle(n);
        chk("restart count", n, LAT);
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****************************************
    // sequence
    // ****************************************
    initial
    begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        t_power_up();
        t_undervolt();
        t_manual();
        t_restart();
        final_report();
    end
endmodule // supply_reset_delay_sequencer_tb_top
`default_nettype wire
